//--- verilog/cantm_pkg.sv
package cantm_pkg;

  // Host clock
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned CLK_KHZ = 1000000 / CLK_PERIOD_NS;

  // Candidate bus rates tried in order by the baud search
  localparam int unsigned RATE_COUNT = 3;
  localparam int unsigned RATE0_KBPS = 125;
  localparam int unsigned RATE1_KBPS = 250;
  localparam int unsigned RATE2_KBPS = 500;
  localparam int unsigned RATE_W = 2;
  localparam logic [RATE_W-1:0] RATE_IDX_RESET = 2'h0;

  // Bit period in clock cycles, rounded down
  localparam int unsigned BIT0_CYCLES = CLK_KHZ / RATE0_KBPS;
  localparam int unsigned BIT1_CYCLES = CLK_KHZ / RATE1_KBPS;
  localparam int unsigned BIT2_CYCLES = CLK_KHZ / RATE2_KBPS;
  localparam int unsigned CNT_W = $clog2(BIT0_CYCLES + 1);

  // Pin levels after reset
  localparam logic TXD_RESET = 1'b1;
  localparam logic LOOP_RESET = 1'b0;
  localparam logic BAUD_RESET = 1'b0;
  localparam logic STBY_RESET = 1'b0;
  localparam logic EN_RESET = 1'b1;

  typedef enum logic [2:0] {
    CANTM_IDLE,
    CANTM_BAUD_RESET,
    CANTM_BAUD_WAIT,
    CANTM_DIAG,
    CANTM_STANDBY
  } cantm_state_e;

  function automatic logic [CNT_W-1:0] cantm_bit_cycles(input logic [RATE_W-1:0] idx);
    logic [CNT_W-1:0] r;
    r = CNT_W'(BIT0_CYCLES);
    if (idx == 2'h1) r = CNT_W'(BIT1_CYCLES);
    if (idx == 2'h2) r = CNT_W'(BIT2_CYCLES);
    return r;
  endfunction

endpackage

//--- verilog/cantm_host.sv
module cantm_host
  import cantm_pkg::*;
#(
  parameter int unsigned DIAG_W = 8
) (
  input wire logic ref_clk,
  input wire logic reset,
  // Orders from the user side
  input wire logic start_autobaud,
  input wire logic start_diag,
  input wire logic [DIAG_W-1:0] diag_pattern,
  input wire logic standby_req,
  // Local protocol controller
  input wire logic ctrl_txd,
  input wire logic ctrl_msg_received,
  input wire logic ctrl_error_warning,
  output logic ctrl_rxd,
  output logic ctrl_reset,
  output logic [RATE_W-1:0] rate_sel,
  output logic rate_locked,
  output logic diag_done,
  output logic diag_pass,
  output logic woke,
  output logic busy,
  // Transceiver pins
  input wire logic rxd_pin,
  output logic txd_pin,
  output logic loopback_select,
  output logic autobaud_select,
  output logic slope_standby_select,
  output logic enable_pin
);

  ////////////////////////////////////////////////////////////////////////////
  // Receive pin synchroniser
  logic rx_meta_q;
  logic rx_sync_q;
  logic rx_prev_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      rx_meta_q <= rxd_pin;
      rx_sync_q <= rx_meta_q;
      rx_prev_q <= rx_sync_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control state
  cantm_state_e state_q, state_d;
  logic [RATE_W-1:0] rate_q, rate_d;
  logic locked_q, locked_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [DIAG_W-1:0] shift_q, shift_d;
  logic [$clog2(DIAG_W+1)-1:0] bits_q, bits_d;
  logic pass_q, pass_d;
  logic done_q, done_d;
  logic woke_q, woke_d;
  logic creset_q, creset_d;
  logic txd_q, txd_d;
  logic loop_q, loop_d;
  logic baud_q, baud_d;
  logic stby_q, stby_d;
  logic rxd_q, rxd_d;
  logic [CNT_W-1:0] bit_len;

  assign bit_len = cantm_bit_cycles(rate_q);

  always_comb begin
    state_d = state_q;
    rate_d = rate_q;
    locked_d = locked_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    bits_d = bits_q;
    pass_d = pass_q;
    done_d = 1'b0;
    woke_d = 1'b0;
    unique case (state_q)
      CANTM_IDLE: begin
        if (start_autobaud) begin
          state_d = CANTM_BAUD_RESET;
          rate_d = RATE_IDX_RESET;
          locked_d = 1'b0;
        end else if (start_diag) begin
          state_d = CANTM_DIAG;
          shift_d = diag_pattern;
          bits_d = '0;
          cnt_d = '0;
          pass_d = 1'b1;
        end else if (standby_req) begin
          state_d = CANTM_STANDBY;
        end
      end
      CANTM_BAUD_RESET: begin
        // Indications during the reset belong to the old rate
        state_d = CANTM_BAUD_WAIT;
      end
      CANTM_BAUD_WAIT: begin
        // Error wins when both arrive together: the frame was not clean
        if (ctrl_error_warning) begin
          state_d = CANTM_BAUD_RESET;
          rate_d = (rate_q == RATE_W'(RATE_COUNT - 1)) ? RATE_IDX_RESET : rate_q + 2'h1;
        end else if (ctrl_msg_received) begin
          state_d = CANTM_IDLE;
          locked_d = 1'b1;
        end
      end
      CANTM_DIAG: begin
        cnt_d = cnt_q + CNT_W'(1);
        // Sample mid-bit; loop delay and synchroniser are far below half a bit
        if (cnt_q == (bit_len >> 1) && rx_sync_q != shift_q[DIAG_W-1]) begin
          pass_d = 1'b0;
        end
        if (cnt_q == bit_len - CNT_W'(1)) begin
          cnt_d = '0;
          shift_d = {shift_q[DIAG_W-2:0], 1'b1};
          bits_d = bits_q + 1'b1;
          if (bits_q == ($clog2(DIAG_W+1))'(DIAG_W - 1)) begin
            state_d = CANTM_IDLE;
            done_d = 1'b1;
          end
        end
      end
      CANTM_STANDBY: begin
        if (rx_prev_q && !rx_sync_q) begin
          state_d = CANTM_IDLE;
          woke_d = 1'b1;
        end else if (!standby_req) begin
          state_d = CANTM_IDLE;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive, all registered except enable_pin, which is tied to EN_RESET
  always_comb begin
    creset_d = (state_d == CANTM_BAUD_RESET);
    baud_d = (state_d == CANTM_BAUD_RESET) || (state_d == CANTM_BAUD_WAIT);
    loop_d = (state_d == CANTM_DIAG);
    stby_d = (state_d == CANTM_STANDBY);
    txd_d = (state_d == CANTM_DIAG) ? shift_d[DIAG_W-1] : ctrl_txd;
    rxd_d = rx_sync_q;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= CANTM_IDLE;
      rate_q <= RATE_IDX_RESET;
      locked_q <= 1'b0;
      cnt_q <= '0;
      shift_q <= '0;
      bits_q <= '0;
      pass_q <= 1'b0;
      done_q <= 1'b0;
      woke_q <= 1'b0;
      creset_q <= 1'b0;
      txd_q <= TXD_RESET;
      loop_q <= LOOP_RESET;
      baud_q <= BAUD_RESET;
      stby_q <= STBY_RESET;
      rxd_q <= 1'b1;
    end else begin
      state_q <= state_d;
      rate_q <= rate_d;
      locked_q <= locked_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      bits_q <= bits_d;
      pass_q <= pass_d;
      done_q <= done_d;
      woke_q <= woke_d;
      creset_q <= creset_d;
      txd_q <= txd_d;
      loop_q <= loop_d;
      baud_q <= baud_d;
      stby_q <= stby_d;
      rxd_q <= rxd_d;
    end
  end

  assign ctrl_rxd = rxd_q;
  assign ctrl_reset = creset_q;
  assign rate_sel = rate_q;
  assign rate_locked = locked_q;
  assign diag_done = done_q;
  assign diag_pass = pass_q;
  assign woke = woke_q;
  assign busy = (state_q != CANTM_IDLE);
  assign txd_pin = txd_q;
  assign loopback_select = loop_q;
  assign autobaud_select = baud_q;
  assign slope_standby_select = stby_q;
  // Transceiver always enabled; a low enable would mute receive data
  assign enable_pin = EN_RESET;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_baud_start;
    state_q == CANTM_IDLE && start_autobaud;
  endsequence

  sequence s_baud_reset_issued;
    ctrl_reset && autobaud_select && rate_sel == RATE_IDX_RESET;
  endsequence

  sequence s_baud_error;
    state_q == CANTM_BAUD_WAIT && ctrl_error_warning;
  endsequence

  AST_BAUD_RAISE: assert property (@(posedge ref_clk) disable iff (reset)
    s_baud_start |=> s_baud_reset_issued ##1 (autobaud_select && !ctrl_reset))
    else $error("autobaud search did not start at first rate");

  AST_BAUD_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
    state_q == CANTM_BAUD_WAIT |-> autobaud_select && !loopback_select && !ctrl_reset)
    else $error("autobaud select dropped while waiting");

  AST_ERR_NEXT: assert property (@(posedge ref_clk) disable iff (reset)
    s_baud_error |=> ctrl_reset && rate_sel != $past(rate_sel) ##1 state_q == CANTM_BAUD_WAIT)
    else $error("error did not step to a new rate");

  AST_ERR_WINS: assert property (@(posedge ref_clk) disable iff (reset)
    s_baud_error |=> !rate_locked && autobaud_select)
    else $error("rate locked despite error warning");

  AST_LOCK: assert property (@(posedge ref_clk) disable iff (reset)
    state_q == CANTM_BAUD_WAIT && ctrl_msg_received && !ctrl_error_warning
      |=> rate_locked && !autobaud_select && rate_sel == $past(rate_sel))
    else $error("clean message did not lock rate");

  AST_DIAG_LOOP: assert property (@(posedge ref_clk) disable iff (reset)
    state_q == CANTM_DIAG |-> loopback_select && !autobaud_select && txd_pin == shift_q[DIAG_W-1])
    else $error("diagnostic without loopback");

  AST_DIAG_END: assert property (@(posedge ref_clk) disable iff (reset)
    diag_done |-> !loopback_select ##1 !diag_done)
    else $error("diagnostic end malformed");

  AST_WAKE: assert property (@(posedge ref_clk) disable iff (reset)
    state_q == CANTM_STANDBY && rx_prev_q && !rx_sync_q |=> !slope_standby_select && woke)
    else $error("standby not left on dominant edge");

  AST_RX_SYNC: assert property (@(posedge ref_clk) disable iff (reset)
    $past(reset, 3) == 1'b0 |-> ctrl_rxd == $past(rxd_pin, 3))
    else $error("receive path latency wrong");

endmodule // cantm_host

//--- verif/cantm_xcvr_model.sv
module cantm_xcvr_model (
  input wire logic txd_pin,
  input wire logic loopback_select,
  input wire logic autobaud_select,
  input wire logic slope_standby_select,
  input wire logic enable_pin,
  input wire logic other_dom,
  input wire logic mid_band,
  output logic rxd_pin,
  output logic drv_dom
);
  timeunit 1ns;
  timeprecision 100ps;
  logic loop_on;
  logic bus_dom;
  // Open pin reads low through the pull-down
  assign loop_on = (loopback_select === 1'b1);
  assign drv_dom = !txd_pin && !loop_on && !autobaud_select
    && !slope_standby_select && enable_pin;
  assign bus_dom = drv_dom || other_dom;
  always_comb begin
    if (!enable_pin) rxd_pin = 1'b1;
    else if (loop_on) rxd_pin = txd_pin;
    else if (mid_band && !(autobaud_select && !txd_pin)) rxd_pin = 1'bx;
    else if (autobaud_select) rxd_pin = !(bus_dom || !txd_pin);
    else rxd_pin = !bus_dom;
  end
endmodule // cantm_xcvr_model

//--- verif/test_can_transceiver_mode_logic.sv
module test_can_transceiver_mode_logic;
  timeunit 1ns;
  timeprecision 100ps;
  import cantm_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic start_autobaud = 1'b0, start_diag = 1'b0, standby_req = 1'b0, ctrl_txd = 1'b1;
  logic ctrl_msg_received = 1'b0, ctrl_error_warning = 1'b0, other_dom = 1'b0;
  logic [7:0] diag_pattern = 8'h00;
  logic [7:0] seed = 8'h15;
  logic ctrl_rxd, ctrl_reset, rate_locked, diag_done, diag_pass, woke, busy, rxd_pin, txd_pin;
  logic loopback_select, autobaud_select, slope_standby_select, enable_pin, drv_dom;
  logic [RATE_W-1:0] rate_sel;
  int n_fail = 0;
  int samples_checked = 0;
  int exp_rate = 0;
  int k;
  ////////////////////////////////////////////////////////////////////////////////
  cantm_host #(.DIAG_W(8)) dut_u (.ref_clk(ref_clk), .reset(reset),
    .start_autobaud(start_autobaud), .start_diag(start_diag), .diag_pattern(diag_pattern),
    .standby_req(standby_req), .ctrl_txd(ctrl_txd), .ctrl_msg_received(ctrl_msg_received),
    .ctrl_error_warning(ctrl_error_warning), .ctrl_rxd(ctrl_rxd), .ctrl_reset(ctrl_reset),
    .rate_sel(rate_sel), .rate_locked(rate_locked), .diag_done(diag_done),
    .diag_pass(diag_pass), .woke(woke), .busy(busy), .rxd_pin(rxd_pin), .txd_pin(txd_pin),
    .loopback_select(loopback_select), .autobaud_select(autobaud_select),
    .slope_standby_select(slope_standby_select), .enable_pin(enable_pin));
  cantm_xcvr_model xcvr_u (.txd_pin(txd_pin), .loopback_select(loopback_select),
    .autobaud_select(autobaud_select), .slope_standby_select(slope_standby_select),
    .enable_pin(enable_pin), .other_dom(other_dom), .mid_band(1'b0), .rxd_pin(rxd_pin),
    .drv_dom(drv_dom));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Bus held dominant by another node to show it cannot leak into the loop
  task automatic diag(input int bc);
    diag_pattern = seed;
    seed = lfsr(seed);
    other_dom = 1'b1;
    start_diag = 1'b1;
    cyc(1);
    start_diag = 1'b0;
    k = 0;
    do begin
      cyc(1);
      k++;
      if ((k - 1) % bc == bc / 2) begin
        check("txd_bit", 16'(txd_pin), 16'(diag_pattern[7 - (k - 1) / bc]));
        check("bus_quiet", 16'(drv_dom), 16'h0000);
      end
    end while (!diag_done && k < 8 * bc + 5);
    check("diag_len", 16'(k), 16'(8 * bc));
    check("diag_pass", 16'(diag_pass), 16'h0001);
    other_dom = 1'b0;
  endtask
  task automatic summarize();
    if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    n_fail++;
    summarize();
  end
  initial begin
    cyc(12);
    reset = 1'b0;
    check("reset_loop", 16'({loopback_select, enable_pin}), 16'h0001);
    check("reset_drive", 16'({txd_pin, autobaud_select}), 16'h0002);
    check("reset_rate", 16'({rate_sel, rate_locked, slope_standby_select}), 16'h0000);
    for (int i = 0; i < 8; i++) begin
      ctrl_txd = seed[0];
      other_dom = seed[1];
      seed = lfsr(seed);
      cyc(6);
      check("drv_dom", 16'(drv_dom), 16'(!ctrl_txd));
      check("rxd_norm", 16'(ctrl_rxd), 16'(ctrl_txd && !other_dom));
    end
    other_dom = 1'b0;
    ctrl_txd = 1'b1;
    diag(BIT0_CYCLES);
    start_autobaud = 1'b1;
    cyc(1);
    start_autobaud = 1'b0;
    // Controller reset pulse stands only in this cycle
    check("baud_start", 16'({busy, ctrl_reset, autobaud_select, rate_sel}), 16'h001c);
    cyc(1);
    ctrl_txd = 1'b0;
    start_diag = 1'b1;
    cyc(6);
    start_diag = 1'b0;
    check("muted", 16'({drv_dom, ctrl_rxd, loopback_select}), 16'h0000);
    ctrl_txd = 1'b1;
    other_dom = 1'b1;
    cyc(6);
    check("baud_rx", 16'(ctrl_rxd), 16'h0000);
    other_dom = 1'b0;
    cyc(6);
    check("baud_rx_idle", 16'(ctrl_rxd), 16'h0001);
    for (int i = 0; i < 4; i++) begin
      ctrl_error_warning = 1'b1;
      ctrl_msg_received = (i == 3);
      cyc(1);
      ctrl_error_warning = 1'b0;
      ctrl_msg_received = 1'b0;
      exp_rate = (exp_rate + 1) % RATE_COUNT;
      check("baud_retry", 16'({ctrl_reset, rate_sel}), 16'(4 + exp_rate));
      cyc(2);
    end
    ctrl_msg_received = 1'b1;
    cyc(1);
    ctrl_msg_received = 1'b0;
    cyc(1);
    check("lock", 16'({autobaud_select, rate_locked, rate_sel}), 16'(4 + exp_rate));
    diag(BIT1_CYCLES);
    standby_req = 1'b1;
    ctrl_txd = 1'b0;
    cyc(2);
    check("stby", 16'({slope_standby_select, drv_dom}), 16'h0002);
    ctrl_txd = 1'b1;
    other_dom = 1'b1;
    k = 0;
    while (!woke && k < 10) begin
      cyc(1);
      k++;
    end
    standby_req = 1'b0;
    check("wake", 16'({woke, slope_standby_select}), 16'h0002);
    cyc(4);
    // Quiet bus: standby left only by dropping the request
    other_dom = 1'b0;
    standby_req = 1'b1;
    cyc(2);
    check("stby_again", 16'(slope_standby_select), 16'h0001);
    standby_req = 1'b0;
    cyc(2);
    check("stby_drop", 16'({woke, slope_standby_select}), 16'h0000);
    summarize();
  end
endmodule // test_can_transceiver_mode_logic
